// ===== rtl/spdse_alert.v
`include "spdse_consts.vh"
// Temperature alert generator; output is the open-drain enable of the alert pin.
module spdse_alert (
	input  wire                     clk,
	input  wire                     reset,
	input  wire [1:0]               mode,
	input  wire                     clear,
	input  wire [`SPDSE_TEMP_W-1:0] temp,
	input  wire [`SPDSE_TEMP_W-1:0] high_limit,
	input  wire [`SPDSE_TEMP_W-1:0] low_limit,
	input  wire [`SPDSE_TEMP_W-1:0] critical_limit,
	input  wire [`SPDSE_TEMP_W-1:0] hyst,
	output reg                      alert_oe
);
	reg  [2:0] zone_reg;
	wire [2:0] zone_next;
	reg        int_reg;
	reg        crit_reg;
	wire       above_high = $signed(temp) > $signed(high_limit);
	wire       below_low  = $signed(temp) < $signed(low_limit);
	wire       above_crit = $signed(temp) > $signed(critical_limit);

	// Zone flags: any change is a limit crossing.
	assign zone_next = {above_crit, above_high, below_low};

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			zone_reg <= 3'h0;
			int_reg  <= 1'b0;
			crit_reg <= 1'b0;
			alert_oe <= 1'b0;
		end else begin
			zone_reg <= zone_next;
			// A crossing in the clear cycle wins, so no event is lost.
			if (zone_next != zone_reg)
				int_reg <= 1'b1;
			else if (clear)
				int_reg <= 1'b0;
			if (above_crit)
				crit_reg <= 1'b1;
			else if ($signed(temp) < $signed(critical_limit - hyst))
				crit_reg <= 1'b0;
			case (mode)
			`SPDSE_MODE_INT: alert_oe <= int_reg;
			`SPDSE_MODE_CMP: begin
				if (above_high || $signed(temp) < $signed(low_limit - hyst))
					alert_oe <= 1'b1;
				else if ($signed(temp) < $signed(high_limit - hyst) && !below_low)
					alert_oe <= 1'b0;
			end
			`SPDSE_MODE_CRIT: alert_oe <= crit_reg;
			default: alert_oe <= 1'b0;
			endcase
		end
	end
endmodule // spdse_alert

// ===== rtl/spdse_consts.vh
`ifndef SPDSE_CONSTS_VH
`define SPDSE_CONSTS_VH
// Function type codes.
`define SPDSE_FTC_MEM       4'hA
`define SPDSE_FTC_PROT      4'h6
`define SPDSE_FTC_SENSOR    4'h3
// Protection-family command codes, address bits 3..1.
`define SPDSE_CMD_SWP0      3'h1
`define SPDSE_CMD_SWP1      3'h4
`define SPDSE_CMD_SWP2      3'h5
`define SPDSE_CMD_SWP3      3'h0
`define SPDSE_CMD_CWP       3'h3
`define SPDSE_CMD_SPA0      3'h6
`define SPDSE_CMD_SPA1      3'h7
// Alert modes.
`define SPDSE_MODE_INT      2'h0
`define SPDSE_MODE_CMP      2'h1
`define SPDSE_MODE_CRIT     2'h2
// Timing.
`define SPDSE_CLK_HZ        100000000
`define SPDSE_TIMEOUT_MS    30
`define SPDSE_TIMEOUT_CYC   ((`SPDSE_CLK_HZ / 1000) * `SPDSE_TIMEOUT_MS)
// Memory organisation and temperature width.
`define SPDSE_MULTI_MAX     16
`define SPDSE_TEMP_W        11
`endif

// ===== rtl/spdse_slave.v
`include "spdse_consts.vh"
module spdse_slave #(
	parameter TIMEOUT_CYC = `SPDSE_TIMEOUT_CYC
) (
	input  wire                     clk,
	input  wire                     reset,
	input  wire                     scl_in,
	input  wire                     sda_in,
	output wire                     sda_out,
	output wire                     sda_oe,
	output wire                     scl_out,
	output wire                     scl_oe,
	input  wire                     select_strap_0,
	input  wire                     select_strap_1,
	input  wire                     select_strap_2,
	input  wire                     write_busy,
	output reg                      sel_mem,
	output reg                      sel_prot,
	output reg                      sel_sensor,
	output reg  [3:0]               sel_cmd,
	output reg                      dir_read,
	output reg                      byte_valid,
	output reg  [7:0]               byte_data,
	output reg  [4:0]               byte_count,
	output reg                      rd_req,
	input  wire [7:0]               rd_data,
	output reg                      write_start,
	output reg                      xfer_end,
	output reg                      page_sel,
	output wire [3:0]               wp_block,
	input  wire [1:0]               alert_mode,
	input  wire                     alert_clear,
	input  wire                     sensor_shutdown_bit,
	input  wire [`SPDSE_TEMP_W-1:0] temp_in,
	input  wire [`SPDSE_TEMP_W-1:0] high_limit,
	input  wire [`SPDSE_TEMP_W-1:0] low_limit,
	input  wire [`SPDSE_TEMP_W-1:0] critical_limit,
	input  wire [`SPDSE_TEMP_W-1:0] hyst,
	output reg  [`SPDSE_TEMP_W-1:0] temp_held,
	output wire                     event_out,
	output wire                     event_oe
);
	localparam ST_IDLE  = 3'h0;
	localparam ST_ADDR  = 3'h1;
	localparam ST_AACK  = 3'h2;
	localparam ST_RX    = 3'h3;
	localparam ST_RXACK = 3'h4;
	localparam ST_TX    = 3'h5;
	localparam ST_TXACK = 3'h6;

	wire scl_s;
	wire sda_s;
	reg  scl_d_reg;
	reg  sda_d_reg;
	reg  [2:0]  state_reg;
	reg  [2:0]  state_next;
	reg  [3:0]  bit_reg;
	reg  [7:0]  shift_reg;
	reg  [7:0]  tx_reg;
	reg         drive_low_reg;
	reg         wrote_reg;
	reg  [31:0] low_cnt_reg;
	wire        scl_rise;
	wire        scl_fall;
	wire        start_det;
	wire        stop_det;
	wire        timeout;
	wire        code_ok;
	wire        mem_code;
	wire        prot_code;
	wire        sens_code;
	wire [2:0]  straps;
	wire [2:0]  strap_pins;
	wire        prot_apply;
	wire [11:0] swp_codes;
	genvar      gi;

	spdse_sync u_sync_scl (
		.clk   (clk),
		.reset (reset),
		.d     (scl_in),
		.q     (scl_s)
	);

	spdse_sync u_sync_sda (
		.clk   (clk),
		.reset (reset),
		.d     (sda_in),
		.q     (sda_s)
	);

	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_strap
			// Straps are board pins, so they pass the same two flops as the bus lines.
			spdse_sync u_sync_strap (
				.clk   (clk),
				.reset (reset),
				.d     (strap_pins[gi]),
				.q     (straps[gi])
			);
		end
	endgenerate

	spdse_alert u_alert (
		.clk            (clk),
		.reset          (reset),
		.mode           (alert_mode),
		.clear          (alert_clear),
		.temp           (temp_held),
		.high_limit     (high_limit),
		.low_limit      (low_limit),
		.critical_limit (critical_limit),
		.hyst           (hyst),
		.alert_oe       (event_oe)
	);

	// Open-drain pins only ever drive low; the clock is never held.
	assign sda_out = 1'b0;
	assign sda_oe  = drive_low_reg;
	assign scl_out = 1'b0;
	assign scl_oe  = 1'b0;
	assign event_out = 1'b0;

	assign strap_pins = {select_strap_2, select_strap_1, select_strap_0};
	assign scl_rise  = scl_s && !scl_d_reg;
	assign scl_fall  = !scl_s && scl_d_reg;
	// A data edge while the clock is high is framing, never data.
	assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
	assign stop_det  = scl_s && scl_d_reg && !sda_d_reg && sda_s;
	assign timeout   = (low_cnt_reg >= TIMEOUT_CYC - 1);

	// The address byte is type code, strap bits, then the direction bit in bit 0.
	assign mem_code  = shift_reg[7:4] == `SPDSE_FTC_MEM;
	assign prot_code = shift_reg[7:4] == `SPDSE_FTC_PROT;
	assign sens_code = shift_reg[7:4] == `SPDSE_FTC_SENSOR;
	assign code_ok   = ((mem_code || sens_code) && shift_reg[3:1] == straps
		|| prot_code)
		&& !((mem_code || prot_code) && write_busy);

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	// Clock low watchdog, restarted on every high level.
	always @(posedge clk or posedge reset) begin
		if (reset)
			low_cnt_reg <= 32'h0;
		else if (scl_s || state_reg == ST_IDLE)
			low_cnt_reg <= 32'h0;
		else if (!timeout)
			low_cnt_reg <= low_cnt_reg + 32'h1;
	end

	always @* begin
		state_next = state_reg;
		case (state_reg)
		ST_IDLE:  state_next = ST_IDLE;
		ST_ADDR:  if (scl_fall && bit_reg == 4'h8)
				state_next = code_ok ? ST_AACK : ST_IDLE;
		ST_AACK:  if (scl_fall)
				state_next = dir_read ? ST_TX : ST_RX;
		ST_RX:    if (scl_fall && bit_reg == 4'h8)
				state_next = ST_RXACK;
		ST_RXACK: if (scl_fall)
				state_next = ST_RX;
		ST_TX:    if (scl_fall && bit_reg == 4'h8)
				state_next = ST_TXACK;
		ST_TXACK: if (scl_rise)
				state_next = sda_s ? ST_IDLE : ST_TX;
		default:  state_next = ST_IDLE;
		endcase
		if (start_det)
			state_next = ST_ADDR;
		else if (stop_det || timeout)
			state_next = ST_IDLE;
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg     <= ST_IDLE;
			bit_reg       <= 4'h0;
			shift_reg     <= 8'h00;
			tx_reg        <= 8'hFF;
			drive_low_reg <= 1'b0;
			wrote_reg     <= 1'b0;
			sel_mem       <= 1'b0;
			sel_prot      <= 1'b0;
			sel_sensor    <= 1'b0;
			sel_cmd       <= 4'h0;
			dir_read      <= 1'b0;
			byte_valid    <= 1'b0;
			byte_data     <= 8'h00;
			byte_count    <= 5'h00;
			rd_req        <= 1'b0;
			write_start   <= 1'b0;
			xfer_end      <= 1'b0;
		end else begin
			state_reg   <= state_next;
			byte_valid  <= 1'b0;
			rd_req      <= 1'b0;
			write_start <= 1'b0;
			xfer_end    <= 1'b0;
			if (scl_rise)
				shift_reg <= {shift_reg[6:0], sda_s};
			if (scl_rise && bit_reg != 4'h8)
				bit_reg <= bit_reg + 4'h1;
			if (start_det || stop_det || timeout) begin
				bit_reg       <= 4'h0;
				drive_low_reg <= 1'b0;
			end
			if (stop_det && state_reg != ST_IDLE) begin
				xfer_end <= 1'b1;
				// A memory write started only by data bytes launches the cycle.
				if (sel_mem && !dir_read && wrote_reg)
					write_start <= 1'b1;
			end
			if (start_det || state_next == ST_IDLE) begin
				sel_mem    <= 1'b0;
				sel_prot   <= 1'b0;
				sel_sensor <= 1'b0;
				wrote_reg  <= 1'b0;
			end
			case (state_reg)
			ST_ADDR: if (scl_fall && bit_reg == 4'h8 && state_next == ST_AACK) begin
				sel_mem       <= mem_code;
				sel_prot      <= prot_code;
				sel_sensor    <= sens_code;
				sel_cmd       <= shift_reg[3:0];
				dir_read      <= shift_reg[0];
				byte_count    <= 5'h00;
				drive_low_reg <= 1'b1;
				if (shift_reg[0])
					rd_req <= 1'b1;
			end
			ST_AACK: if (scl_fall) begin
				bit_reg       <= 4'h0;
				drive_low_reg <= 1'b0;
				if (dir_read) begin
					tx_reg        <= {rd_data[6:0], 1'b1};
					drive_low_reg <= !rd_data[7];
				end
			end
			ST_RX: if (scl_fall && bit_reg == 4'h8) begin
				byte_valid    <= 1'b1;
				byte_data     <= shift_reg;
				drive_low_reg <= 1'b1;
				if (byte_count != 5'h1F)
					byte_count <= byte_count + 5'h01;
				// Bytes beyond the address and a full group are left to the memory side.
				if (byte_count >= 5'h01 && byte_count <= `SPDSE_MULTI_MAX)
					wrote_reg <= 1'b1;
			end
			ST_RXACK: if (scl_fall) begin
				bit_reg       <= 4'h0;
				drive_low_reg <= 1'b0;
			end
			ST_TX: if (scl_fall) begin
				if (bit_reg == 4'h8) begin
					drive_low_reg <= 1'b0;
					byte_count    <= byte_count + 5'h01;
				end else begin
					drive_low_reg <= !tx_reg[7];
					tx_reg        <= {tx_reg[6:0], 1'b1};
				end
			end
			ST_TXACK: if (scl_rise && !sda_s)
				rd_req <= 1'b1;
			default: ;
			endcase
			if (state_reg == ST_TXACK && state_next == ST_TX) begin
				bit_reg <= 4'h0;
			end
			if (state_reg == ST_TX && scl_fall && bit_reg == 4'h0 && byte_count != 5'h00) begin
				tx_reg        <= {rd_data[6:0], 1'b1};
				drive_low_reg <= !rd_data[7];
			end
		end
	end

	// Protection-family commands act only on a stop, so a cut frame changes nothing.
	assign prot_apply = stop_det && sel_prot && !dir_read;
	assign swp_codes  = {`SPDSE_CMD_SWP3, `SPDSE_CMD_SWP2, `SPDSE_CMD_SWP1, `SPDSE_CMD_SWP0};

	// These settings live in flops, so a reset clears them; keeping them is the memory side's job.
	always @(posedge clk or posedge reset) begin
		if (reset)
			page_sel <= 1'b0;
		else if (prot_apply && sel_cmd[3:1] == `SPDSE_CMD_SPA0)
			page_sel <= 1'b0;
		else if (prot_apply && sel_cmd[3:1] == `SPDSE_CMD_SPA1)
			page_sel <= 1'b1;
	end

	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_wp
			reg wp_bit_reg;
			always @(posedge clk or posedge reset) begin
				if (reset)
					wp_bit_reg <= 1'b0;
				else if (prot_apply && sel_cmd[3:1] == swp_codes[3*gi +: 3])
					wp_bit_reg <= 1'b1;
				else if (prot_apply && sel_cmd[3:1] == `SPDSE_CMD_CWP)
					wp_bit_reg <= 1'b0;
			end
			assign wp_block[gi] = wp_bit_reg;
		end
	endgenerate

	// Sensor readings freeze while shut down and stay readable.
	always @(posedge clk or posedge reset) begin
		if (reset)
			temp_held <= {`SPDSE_TEMP_W{1'b0}};
		else if (!sensor_shutdown_bit)
			temp_held <= temp_in;
	end
endmodule // spdse_slave

// ===== rtl/spdse_sync.v
// Two-flop synchroniser for one asynchronous level.
module spdse_sync (
	input  wire clk,
	input  wire reset,
	input  wire d,
	output reg  q
);
	reg meta_reg;

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_reg <= 1'b1;
			q        <= 1'b1;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule // spdse_sync

// ===== testbench/spd_serial_slave_event_out_tb_top.sv
module spd_serial_slave_event_out_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam TO = 2000;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic select_strap_0 = 1'b1, select_strap_1 = 1'b0, select_strap_2 = 1'b1;
	logic write_busy = 1'b0, alert_clear = 1'b0, sensor_shutdown_bit = 1'b0;
	logic [7:0] rd_data = 8'h40;
	logic [1:0] alert_mode = 2'h1;
	logic [10:0] temp_in = 11'h032, high_limit = 11'h064, low_limit = 11'h00A;
	logic [10:0] critical_limit = 11'h078, hyst = 11'h005;
	wire scl_in, sda_in, sda_out, sda_oe, scl_out, scl_oe, sel_mem, sel_prot, sel_sensor, dir_read;
	wire byte_valid, rd_req, write_start, xfer_end, event_out, event_oe, page_sel;
	wire [3:0] sel_cmd, wp_block;
	wire [7:0] byte_data;
	wire [4:0] byte_count;
	wire [10:0] temp_held;
	int err_total = 0;
	int samples_checked = 0;
	int ws_cnt = 0;
	int xe_cnt = 0;
	logic a;
	logic [7:0] b;
	spdse_slave #(.TIMEOUT_CYC(TO)) uut (
		.clk, .reset, .scl_in, .sda_in, .sda_out, .sda_oe, .scl_out, .scl_oe,
		.select_strap_0, .select_strap_1, .select_strap_2, .write_busy, .sel_mem, .sel_prot,
		.sel_sensor, .sel_cmd, .dir_read, .byte_valid, .byte_data, .byte_count, .rd_req, .rd_data,
		.write_start, .xfer_end, .page_sel, .wp_block, .alert_mode, .alert_clear, .sensor_shutdown_bit, .temp_in,
		.high_limit, .low_limit, .critical_limit, .hyst, .temp_held, .event_out, .event_oe
	);
	spdse_host host (.clk, .dev_sda_oe(sda_oe), .dev_scl_oe(scl_oe), .scl_line(scl_in), .sda_line(sda_in));
	always #5 clk = ~clk;
	always @(posedge clk) begin
		if (write_start === 1'b1)
			ws_cnt++;
		if (xfer_end === 1'b1)
			xe_cnt++;
		if (rd_req === 1'b1)
			rd_data <= rd_data + 8'h01;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks=%0d errors=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic xa(input logic st, input logic [7:0] v, input logic e);
		if (st)
			host.start();
		host.wbyte(v, a);
		chk(a, e);
	endtask
	// Clear is a one-cycle pulse; the output is read once the held sample has settled.
	task automatic astep(input logic [1:0] m, input logic [10:0] t, input logic c, s, e);
		@(posedge clk);
		alert_mode <= m;
		temp_in <= t;
		alert_clear <= c;
		sensor_shutdown_bit <= s;
		@(posedge clk);
		alert_clear <= 1'b0;
		repeat (5) @(posedge clk);
		#1 chk(event_oe, e);
	endtask
	initial begin
		#500000;
		err_total++;
		stop_test();
	end
	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
		xa(1'b1, 8'hA0, 1'b0);
		host.stop();
		xa(1'b1, 8'hAA, 1'b1);
		chk(sel_mem, 1'b1);
		chk(sel_cmd, 4'hA);
		xa(1'b0, 8'h12, 1'b1);
		chk(byte_data, 8'h12);
		xa(1'b0, 8'h34, 1'b1);
		chk(byte_data, 8'h34);
		chk(byte_count, 5'h02);
		host.stop();
		chk(ws_cnt, 1);
		select_strap_0 <= 1'b0;
		select_strap_2 <= 1'b0;
		xa(1'b1, 8'hA0, 1'b1);
		host.stop();
		chk(ws_cnt, 1);
		write_busy <= 1'b1;
		xa(1'b1, 8'hA0, 1'b0);
		xa(1'b1, 8'h6C, 1'b0);
		xa(1'b1, 8'h30, 1'b1);
		chk(sel_sensor, 1'b1);
		host.stop();
		write_busy <= 1'b0;
		xa(1'b1, 8'h6E, 1'b1);
		chk(sel_prot, 1'b1);
		host.stop();
		chk(sel_prot, 1'b0);
		chk(page_sel, 1'b1);
		xa(1'b1, 8'h62, 1'b1);
		host.stop();
		chk(wp_block, 4'h1);
		xa(1'b1, 8'h31, 1'b1);
		chk(dir_read, 1'b1);
		host.rbyte(1'b0, b);
		chk(b, 8'h41);
		host.rbyte(1'b1, b);
		chk(b, 8'h42);
		host.stop();
		chk(sel_sensor, 1'b0);
		xa(1'b1, 8'hA0, 1'b1);
		host.lowfor(TO - 500);
		chk(sel_mem, 1'b1);
		host.lowfor(TO + 100);
		chk(sel_mem, 1'b0);
		host.stop();
		astep(2'h1, 11'h065, 1'b0, 1'b0, 1'b1);
		astep(2'h1, 11'h061, 1'b0, 1'b0, 1'b1);
		astep(2'h1, 11'h05E, 1'b0, 1'b0, 1'b0);
		astep(2'h1, 11'h007, 1'b0, 1'b0, 1'b0);
		astep(2'h1, 11'h004, 1'b0, 1'b0, 1'b1);
		astep(2'h1, 11'h008, 1'b0, 1'b0, 1'b1);
		astep(2'h1, 11'h00B, 1'b0, 1'b0, 1'b0);
		astep(2'h1, 11'h032, 1'b0, 1'b1, 1'b0);
		astep(2'h1, 11'h065, 1'b0, 1'b1, 1'b0);
		chk(temp_held, 11'h00B);
		astep(2'h1, 11'h065, 1'b0, 1'b0, 1'b1);
		astep(2'h2, 11'h065, 1'b0, 1'b0, 1'b0);
		astep(2'h2, 11'h078, 1'b0, 1'b0, 1'b0);
		astep(2'h2, 11'h079, 1'b0, 1'b0, 1'b1);
		astep(2'h2, 11'h074, 1'b0, 1'b0, 1'b1);
		astep(2'h2, 11'h072, 1'b0, 1'b0, 1'b0);
		astep(2'h2, 11'h004, 1'b0, 1'b0, 1'b0);
		astep(2'h0, 11'h004, 1'b1, 1'b0, 1'b0);
		astep(2'h0, 11'h032, 1'b0, 1'b0, 1'b1);
		astep(2'h0, 11'h033, 1'b0, 1'b0, 1'b1);
		astep(2'h0, 11'h033, 1'b1, 1'b0, 1'b0);
		astep(2'h0, 11'h065, 1'b0, 1'b0, 1'b1);
		astep(2'h0, 11'h065, 1'b1, 1'b0, 1'b0);
		astep(2'h0, 11'h032, 1'b0, 1'b0, 1'b1);
		chk(xe_cnt, 5);
		stop_test();
	end
endmodule // spd_serial_slave_event_out_tb_top

// ===== testbench/spdse_host.sv
module spdse_host (
	input  wire clk,
	input  wire dev_sda_oe,
	input  wire dev_scl_oe,
	output wire scl_line,
	output wire sda_line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic h_scl = 1'b1;
	logic h_sda = 1'b1;
	// Both lines have pull-ups, so a released line reads high.
	assign scl_line = h_scl & ~dev_scl_oe;
	assign sda_line = h_sda & ~dev_sda_oe;
	// Start is cond(1,0), stop is cond(0,1); data moves only with the clock high at the end.
	task automatic cond(input logic a, input logic b);
		@(posedge clk);
		h_scl <= 1'b0;
		@(posedge clk);
		h_sda <= a;
		repeat (3) @(posedge clk);
		h_scl <= 1'b1;
		repeat (4) @(posedge clk);
		h_sda <= b;
		repeat (5) @(posedge clk);
	endtask
	task automatic start();
		cond(1'b1, 1'b0);
	endtask
	task automatic stop();
		cond(1'b0, 1'b1);
	endtask
	// One bit of 80 ns; the data line is changed one cycle after the clock falls.
	task automatic bit_io(input logic v, output logic r);
		@(posedge clk);
		h_scl <= 1'b0;
		@(posedge clk);
		h_sda <= v;
		repeat (3) @(posedge clk);
		h_scl <= 1'b1;
		repeat (3) @(posedge clk);
		r = sda_line;
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic rbyte(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			b[i] = r;
		end
		bit_io(last, r);
	endtask
	task automatic lowfor(input int n);
		@(posedge clk);
		h_scl <= 1'b0;
		repeat (n) @(posedge clk);
		h_scl <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
endmodule // spdse_host

// ===== testbench/spdse_props.sv
`include "spdse_consts.vh"
module spdse_props #(
	parameter TIMEOUT_CYC = 2000
) (
	input wire        clk,
	input wire        reset,
	input wire        scl_in,
	input wire        sda_out,
	input wire        scl_oe,
	input wire        event_out,
	input wire        write_busy,
	input wire        sel_mem,
	input wire        byte_valid,
	input wire        write_start,
	input wire        event_oe,
	input wire [1:0]  alert_mode,
	input wire        alert_clear,
	input wire [10:0] temp_held,
	input wire [10:0] high_limit,
	input wire [10:0] low_limit,
	input wire [10:0] critical_limit,
	input wire [10:0] hyst
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        is_cmp;
	logic        is_crit;
	logic [31:0] low_cnt_reg;
	assign is_cmp = alert_mode == `SPDSE_MODE_CMP;
	assign is_crit = alert_mode == `SPDSE_MODE_CRIT;
	// Counts raw clock-low cycles; the margin covers the design's synchroniser delay.
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			low_cnt_reg <= 32'h0;
		else if (scl_in)
			low_cnt_reg <= 32'h0;
		else
			low_cnt_reg <= low_cnt_reg + 32'h1;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	AST_SDA_OD: assert property (sda_out == 1'b0)
		else $error("data pin driven high");
	AST_EVT_OD: assert property (event_out == 1'b0)
		else $error("alert pin driven high");
	AST_NO_STRETCH: assert property (scl_oe == 1'b0)
		else $error("clock line pulled low");
	AST_CMP_SET: assert property (is_cmp && $signed(temp_held) > $signed(high_limit) |-> ##[0:2] event_oe)
		else $error("comparator alert missing");
	AST_CMP_CLR: assert property (is_cmp && $signed(temp_held) < $signed(high_limit - hyst)
		&& $signed(temp_held) > $signed(low_limit) |-> ##[0:2] !event_oe)
		else $error("comparator alert stuck");
	AST_CRIT_SET: assert property (is_crit && $signed(temp_held) > $signed(critical_limit) |-> ##[0:2] event_oe)
		else $error("critical alert missing");
	AST_CRIT_CLR: assert property (is_crit && $signed(temp_held) < $signed(critical_limit - hyst)
		|-> ##[0:2] !event_oe)
		else $error("critical alert stuck");
	AST_INT_HOLD: assert property (alert_mode == `SPDSE_MODE_INT && $past(alert_mode) == `SPDSE_MODE_INT
		&& event_oe && !$past(alert_clear) |=> event_oe)
		else $error("latched alert dropped without clear");
	AST_BUSY_NOACK: assert property (write_busy && $past(write_busy) |-> !$rose(sel_mem))
		else $error("memory selected while busy");
	AST_BYTE_PULSE: assert property (byte_valid |=> !byte_valid)
		else $error("byte strobe longer than one cycle");
	AST_TIMEOUT: assert property (low_cnt_reg > TIMEOUT_CYC + 8 |-> !sel_mem)
		else $error("interface not reset after clock low");
	COV_WRITE: cover property (write_start);
	COV_ALERT: cover property ($rose(event_oe));
	COV_DESEL: cover property ($fell(sel_mem));
endmodule // spdse_props

bind spdse_slave spdse_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_props (
	.clk, .reset, .scl_in, .sda_out, .scl_oe, .event_out, .write_busy, .sel_mem, .byte_valid,
	.write_start, .event_oe, .alert_mode, .alert_clear, .temp_held, .high_limit, .low_limit,
	.critical_limit, .hyst
);
